// File: flash_stat_assertions.sv
// Concurrent checks on the status and security-area command logic
`timescale 1ns/100ps
module stat_chk (
  // Clock, reset and pins
  input wire logic                     CLK_SYS,
  input wire logic                     RESET,
  input wire logic                     CS_N,
  input wire logic                     SCK,
  input wire logic                     SO,
  input wire logic                     SO_OE_N,
  input wire logic                     WP_N,
  // Core and status
  input wire flash_stat_pkg::core_in_t CORE_IN,
  input wire logic                     SECTOR_LOCK_BIT,
  input wire logic                     PROT_ALLOW,
  input wire logic                     RESET_COMMAND_ENABLE,
  input wire logic                     ERASE_PROGRAM_ERROR_FLAG
);
  default clocking @(posedge CLK_SYS);
  endclocking
  default disable iff (RESET);
  sequence s_wp_low; (!WP_N) [*6]; endsequence
  sequence s_cs_high; CS_N [*6]; endsequence
  property p_allow; PROT_ALLOW == !SECTOR_LOCK_BIT; endproperty
  a_allow: assert property (p_allow) else $error("allow wrong");
  property p_off; s_cs_high |-> SO_OE_N && !SO; endproperty
  a_off: assert property (p_off) else $error("output not off");
  property p_err; CORE_IN.op_done |=> ERASE_PROGRAM_ERROR_FLAG == $past(CORE_IN.op_fail); endproperty
  a_err: assert property (p_err) else $error("error not updated");
  property p_hold; !CORE_IN.op_done |=> $stable(ERASE_PROGRAM_ERROR_FLAG); endproperty
  a_hold: assert property (p_hold) else $error("error moved");
  property p_rst; $fell(RESET) |-> !SECTOR_LOCK_BIT && !RESET_COMMAND_ENABLE; endproperty
  a_rst: assert property (p_rst) else $error("reset values");
  property p_lock; s_wp_low ##0 SECTOR_LOCK_BIT |=> SECTOR_LOCK_BIT; endproperty
  a_lock: assert property (p_lock) else $error("lock cleared");
  property p_quiet; s_cs_high |=> $stable({SECTOR_LOCK_BIT, RESET_COMMAND_ENABLE}); endproperty
  a_quiet: assert property (p_quiet) else $error("write outside frame");
  property p_oe; $fell(SO_OE_N) |-> !CS_N && !$past(CS_N, 4); endproperty
  a_oe: assert property (p_oe) else $error("drive unselected");
  property p_edge; $changed(SO) && !SO_OE_N && !$past(SO_OE_N) |-> !$past(SCK, 3); endproperty
  a_edge: assert property (p_edge) else $error("output not on fall");
endmodule
bind flash_stat_ctrl stat_chk i_stat_chk (.CLK_SYS(CLK_SYS), .RESET(RESET), .CS_N(CS_N),
  .SCK(SCK), .SO(SO), .SO_OE_N(SO_OE_N), .WP_N(WP_N), .CORE_IN(CORE_IN),
  .SECTOR_LOCK_BIT(SECTOR_LOCK_BIT), .PROT_ALLOW(PROT_ALLOW),
  .RESET_COMMAND_ENABLE(RESET_COMMAND_ENABLE),
  .ERASE_PROGRAM_ERROR_FLAG(ERASE_PROGRAM_ERROR_FLAG));

// File: flash_stat_ctrl.sv
// Serial command logic for security-area read and the status register
//
// Summary of operation
// - Opcode 77h starts a security-area read.
// - Three address bytes then two dummy bytes precede any output.
// - After those, each further clock shifts out one security-area data bit.
// - After byte 7Fh the read wraps to byte 00h without delay.
// - Chip select high ends any read and floats serial output.
// - Opcode 05h makes the device shift status bits out on every clock.
// - Two status bytes go MSB first, repeating with fresh values.
// - Status reads are served at any time, even while busy.
// - Lock bit 7 set blocks all sector protect and unprotect changes.
// - Lock bit clears at power-up and device reset.
// - With protect pin asserted the lock may only go from 0 to 1.
// - Writing status byte one changes only bit 7.
// - Bit 6 shows sequential program mode, clear after reset.
// - Bit 5 sets when the latest erase or program failed.
// - Aborted erase or program never sets the error bit.
// - Error bit is refreshed at every erase or program completion.
// - Bit 4 is 0 with protect pin asserted, 1 otherwise.
// - Bits 3:2 report none 00, some 01, all 11; never 10.
// - Bit 1 shows the write-enable latch.
// - Bit 0 is 1 while an internal operation runs.
// - Byte two: reset-enable at bit 4, busy copy at bit 0, rest zero.
`timescale 1ns/100ps
module flash_stat_ctrl (
  // System
  input  wire logic                     CLK_SYS,
  input  wire logic                     RESET,
  // Serial pins
  input  wire logic                     CS_N,
  input  wire logic                     SCK,
  input  wire logic                     SI,
  output logic                          SO,
  output logic                          SO_OE_N,
  // Write-protect pin
  input  wire logic                     WP_N,
  // Array and protection logic
  input  wire flash_stat_pkg::core_in_t CORE_IN,
  input  wire flash_stat_pkg::otp_wr_t  OTP_WR,
  // Status to the rest of the device
  output logic                          SECTOR_LOCK_BIT,
  output logic                          PROT_ALLOW,
  output logic                          RESET_COMMAND_ENABLE,
  output logic                          ERASE_PROGRAM_ERROR_FLAG
);

  flash_stat_pkg::state_t q;
  flash_stat_pkg::state_t n;

  logic [7:0]  otp_rdata;
  logic        sck_rise;
  logic        sck_fall;
  logic        cs_n;
  logic        si;
  logic        wp_asserted;
  logic        byte_done;
  logic [7:0]  byte_in;
  logic [1:0]  software_protection_summary;
  logic [7:0]  stat1;
  logic [7:0]  stat2;
  logic [15:0] stat_word;

  otp_array u_otp (
    .clk_sys (CLK_SYS),
    .reset   (RESET),
    .wr      (OTP_WR),
    .raddr   (q.addr),
    .rdata   (otp_rdata)
  );

  // Pin views from the second synchroniser stage only
  assign cs_n        = q.s2[flash_stat_pkg::PIN_CS];
  assign si          = q.s2[flash_stat_pkg::PIN_SI];
  assign wp_asserted = ~q.s2[flash_stat_pkg::PIN_WP];
  assign sck_rise    = q.s2[flash_stat_pkg::PIN_SCK] & ~q.sck_prev;
  assign sck_fall    = ~q.s2[flash_stat_pkg::PIN_SCK] & q.sck_prev;

  assign byte_in   = {q.sh[6:0], si};
  assign byte_done = sck_rise && (q.bcnt == flash_stat_pkg::LAST_BIT);

  // Protection summary, code 10 never produced
  always_comb begin
    if (CORE_IN.prot_all) begin
      software_protection_summary = flash_stat_pkg::SWP_ALL;
    end else if (CORE_IN.prot_any) begin
      software_protection_summary = flash_stat_pkg::SWP_SOME;
    end else begin
      software_protection_summary = flash_stat_pkg::SWP_NONE;
    end
  end

  // Live status bytes, sampled when each repetition starts
  always_comb begin
    stat1 = 8'h00;
    stat2 = 8'h00;
    stat1[flash_stat_pkg::B1_LOCK] = q.lock;
    stat1[flash_stat_pkg::B1_SEQ]  = CORE_IN.seq_mode;
    stat1[flash_stat_pkg::B1_ERR]  = q.err;
    stat1[flash_stat_pkg::B1_WP]   = ~wp_asserted;
    stat1[flash_stat_pkg::B1_SWP_HI:flash_stat_pkg::B1_SWP_LO] = software_protection_summary;
    stat1[flash_stat_pkg::B1_WEL]  = CORE_IN.write_enable_latch;
    stat1[flash_stat_pkg::B1_BUSY] = CORE_IN.busy;
    stat2[flash_stat_pkg::B2_RESET_COMMAND_ENABLE] = q.reset_command_enable;
    stat2[flash_stat_pkg::B2_BUSY] = CORE_IN.busy;
    stat_word = {stat1, stat2};
  end

  always_comb begin
    n = q;

    // Two-stage synchronisers, then edge history
    n.s1       = {WP_N, SI, SCK, CS_N};
    n.s2       = q.s1;
    n.sck_prev = q.s2[flash_stat_pkg::PIN_SCK];

    // Error flag follows each completed operation only
    if (CORE_IN.op_done) begin
      n.err = CORE_IN.op_fail;
    end

    if (cs_n) begin
      // Deselect ends everything, even mid-byte
      n.ph      = flash_stat_pkg::PH_CMD;
      n.bcnt    = 3'h0;
      n.ncnt    = 3'h0;
      n.oidx    = 4'h0;
      n.so      = 1'b0;
      n.so_oe_n = 1'b1;
    end else begin
      if (sck_rise) begin
        n.sh   = byte_in;
        n.bcnt = q.bcnt + 3'h1;
      end

      if (byte_done) begin
        unique case (q.ph)
          flash_stat_pkg::PH_CMD: begin
            if (byte_in == flash_stat_pkg::OP_OTP_READ) begin
              n.ph   = flash_stat_pkg::PH_ADDR;
              n.ncnt = 3'h0;
            end else if (byte_in == flash_stat_pkg::OP_STAT_READ) begin
              n.ph   = flash_stat_pkg::PH_STAT;
              n.oidx = 4'h0;
            end else if (byte_in == flash_stat_pkg::OP_STAT_WR1) begin
              n.ph = flash_stat_pkg::PH_WR1;
            end else if (byte_in == flash_stat_pkg::OP_STAT_WR2) begin
              n.ph = flash_stat_pkg::PH_WR2;
            end else begin
              n.ph = flash_stat_pkg::PH_SKIP;
            end
          end
          flash_stat_pkg::PH_ADDR: begin
            // Only the low seven address bits select a byte
            n.addr = byte_in[6:0];
            if (q.ncnt == flash_stat_pkg::ADDR_BYTES - 3'h1) begin
              n.ph   = flash_stat_pkg::PH_DUMMY;
              n.ncnt = 3'h0;
            end else begin
              n.ncnt = q.ncnt + 3'h1;
            end
          end
          flash_stat_pkg::PH_DUMMY: begin
            if (q.ncnt == flash_stat_pkg::DUMMY_BYTES - 3'h1) begin
              n.ph   = flash_stat_pkg::PH_OTP;
              n.oidx = 4'h0;
            end else begin
              n.ncnt = q.ncnt + 3'h1;
            end
          end
          flash_stat_pkg::PH_WR1: begin
            // Only the lock bit is writable, and only when enabled
            if (CORE_IN.write_enable_latch) begin
              if (!wp_asserted || byte_in[flash_stat_pkg::B1_LOCK]) begin
                n.lock = byte_in[flash_stat_pkg::B1_LOCK];
              end
            end
            n.ph = flash_stat_pkg::PH_SKIP;
          end
          flash_stat_pkg::PH_WR2: begin
            if (CORE_IN.write_enable_latch) begin
              n.reset_command_enable = byte_in[flash_stat_pkg::B2_RESET_COMMAND_ENABLE];
            end
            n.ph = flash_stat_pkg::PH_SKIP;
          end
          flash_stat_pkg::PH_OTP,
          flash_stat_pkg::PH_STAT,
          flash_stat_pkg::PH_SKIP: begin
            n.ph = q.ph;
          end
        endcase
      end

      // Output shifts on falling edges
      if (sck_fall && q.ph == flash_stat_pkg::PH_OTP) begin
        n.so_oe_n = 1'b0;
        n.oidx    = q.oidx + 4'h1;
        if (q.oidx[2:0] == 3'h0) begin
          n.so  = otp_rdata[7];
          n.osh = {otp_rdata[6:0], 9'h000};
          if (q.addr == flash_stat_pkg::OTP_LAST) begin
            n.addr = flash_stat_pkg::OTP_FIRST;
          end else begin
            n.addr = q.addr + 7'h01;
          end
        end else begin
          n.so  = q.osh[15];
          n.osh = {q.osh[14:0], 1'b0};
        end
      end

      if (sck_fall && q.ph == flash_stat_pkg::PH_STAT) begin
        n.so_oe_n = 1'b0;
        n.oidx    = q.oidx + 4'h1;
        if (q.oidx == 4'h0) begin
          // Fresh snapshot at the start of each two-byte pass
          n.so  = stat_word[15];
          n.osh = {stat_word[14:0], 1'b0};
        end else begin
          n.so  = q.osh[15];
          n.osh = {q.osh[14:0], 1'b0};
        end
      end
    end

    n.prot_allow = ~n.lock;
  end

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      q <= flash_stat_pkg::STATE_RST;
    end else begin
      q <= n;
    end
  end

  // Outputs straight from the state register
  assign SO                       = q.so;
  assign SO_OE_N                  = q.so_oe_n;
  assign SECTOR_LOCK_BIT          = q.lock;
  assign PROT_ALLOW               = q.prot_allow;
  assign RESET_COMMAND_ENABLE     = q.reset_command_enable;
  assign ERASE_PROGRAM_ERROR_FLAG = q.err;

endmodule

// File: flash_stat_pkg.sv
// Constants and types for the status and security-area read logic
package flash_stat_pkg;

  // Opcodes
  localparam logic [7:0] OP_OTP_READ  = 8'h77;
  localparam logic [7:0] OP_STAT_READ = 8'h05;
  localparam logic [7:0] OP_STAT_WR1  = 8'h01;
  localparam logic [7:0] OP_STAT_WR2  = 8'h31;

  // Byte counts after the security-area read opcode
  localparam logic [2:0] ADDR_BYTES  = 3'h3;
  localparam logic [2:0] DUMMY_BYTES = 3'h2;
  localparam logic [2:0] LAST_BIT    = 3'h7;

  // Security area
  localparam int         OTP_DEPTH = 128;
  localparam logic [6:0] OTP_FIRST = 7'h00;
  localparam logic [6:0] OTP_LAST  = 7'h7F;
  localparam logic [7:0] OTP_RST   = 8'hFF;

  // Status byte one field positions
  localparam int B1_LOCK   = 7;
  localparam int B1_SEQ    = 6;
  localparam int B1_ERR    = 5;
  localparam int B1_WP     = 4;
  localparam int B1_SWP_HI = 3;
  localparam int B1_SWP_LO = 2;
  localparam int B1_WEL    = 1;
  localparam int B1_BUSY   = 0;

  // Status byte two field positions
  localparam int B2_RESET_COMMAND_ENABLE = 4;
  localparam int B2_BUSY = 0;

  // Software protection summary codes
  localparam logic [1:0] SWP_NONE = 2'h0;
  localparam logic [1:0] SWP_SOME = 2'h1;
  localparam logic [1:0] SWP_ALL  = 2'h3;

  // Synchroniser lanes
  localparam int         PIN_CS  = 0;
  localparam int         PIN_SCK = 1;
  localparam int         PIN_SI  = 2;
  localparam int         PIN_WP  = 3;
  localparam logic [3:0] PIN_RST = 4'hF;

  typedef enum logic [2:0] {
    PH_CMD   = 3'b000,
    PH_ADDR  = 3'b001,
    PH_DUMMY = 3'b010,
    PH_OTP   = 3'b011,
    PH_STAT  = 3'b100,
    PH_WR1   = 3'b101,
    PH_WR2   = 3'b110,
    PH_SKIP  = 3'b111
  } phase_t;

  // Inputs from the array and protection logic, same clock
  typedef struct packed {
    logic busy;
    logic seq_mode;
    logic write_enable_latch;
    logic op_done;
    logic op_fail;
    logic prot_any;
    logic prot_all;
  } core_in_t;

  // Security-area write port
  typedef struct packed {
    logic       we;
    logic [6:0] addr;
    logic [7:0] data;
  } otp_wr_t;

  typedef struct packed {
    logic [3:0]  s1;
    logic [3:0]  s2;
    logic        sck_prev;
    phase_t      ph;
    logic [2:0]  bcnt;
    logic [2:0]  ncnt;
    logic [7:0]  sh;
    logic [3:0]  oidx;
    logic [15:0] osh;
    logic [6:0]  addr;
    logic        so;
    logic        so_oe_n;
    logic        lock;
    logic        err;
    logic        reset_command_enable;
    logic        prot_allow;
  } state_t;

  localparam state_t STATE_RST = '{
    s1: PIN_RST, s2: PIN_RST, sck_prev: 1'b1, ph: PH_CMD,
    so_oe_n: 1'b1, prot_allow: 1'b1, default: '0};

endpackage

// File: otp_array.sv
// Security-area storage, 128 bytes, erased to all ones at reset
`timescale 1ns/100ps
module otp_array (
  // Clock and reset
  input  wire logic                   clk_sys,
  input  wire logic                   reset,
  // Write port
  input  wire flash_stat_pkg::otp_wr_t wr,
  // Read port
  input  wire logic [6:0]             raddr,
  output logic      [7:0]             rdata
);

  typedef struct packed {
    logic [flash_stat_pkg::OTP_DEPTH-1:0][7:0] mem;
  } mem_state_t;

  mem_state_t q;
  mem_state_t n;

  always_comb begin
    n = q;
    if (wr.we) begin
      n.mem[wr.addr] = wr.data;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      q.mem <= {flash_stat_pkg::OTP_DEPTH{flash_stat_pkg::OTP_RST}};
    end else begin
      q <= n;
    end
  end

  assign rdata = q.mem[raddr];

endmodule

// File: otp_read_and_status_register_bench.sv
// Self-checking bench for the status and security-area command logic
`timescale 1ns/100ps
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin err_total++; \
  $display("BAD %s exp %h got %h", n, e, s); end end
module otp_read_and_status_register_bench;
  logic                     clk_sys, reset, wp_n, cs_n, sck, si, so, so_oe_n;
  logic                     lock, allow, reset_command_enable, eflag;
  logic [7:0]               rx;
  logic [7:0]               otp_m [128];
  logic [17:0]              tbl [6];
  flash_stat_pkg::core_in_t core_in;
  flash_stat_pkg::otp_wr_t  otp_wr;
  int                       err_total, comparisons, cyc, lock_m, reset_command_enable_m, err_m;
  flash_stat_ctrl i_flash_stat_ctrl (.CLK_SYS(clk_sys), .RESET(reset), .CS_N(cs_n),
    .SCK(sck), .SI(si), .SO(so), .SO_OE_N(so_oe_n), .WP_N(wp_n), .CORE_IN(core_in),
    .OTP_WR(otp_wr), .SECTOR_LOCK_BIT(lock), .PROT_ALLOW(allow),
    .RESET_COMMAND_ENABLE(reset_command_enable), .ERASE_PROGRAM_ERROR_FLAG(eflag));
  spi_host_model host (.cs_n(cs_n), .sck(sck), .si(si), .so(so), .so_oe_n(so_oe_n));
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 40000) begin
      err_total++;
      final_report();
    end
  end
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic tick();
    @(posedge clk_sys);
    #1;
  endtask
  function automatic logic [15:0] stat_m();
    logic [1:0] software_protection_summary;
    software_protection_summary = core_in.prot_all ? 2'h3 : {1'b0, core_in.prot_any};
    return {lock_m[0], core_in.seq_mode, err_m[0], wp_n, software_protection_summary, core_in.write_enable_latch, core_in.busy,
      3'h0, reset_command_enable_m[0], 3'h0, core_in.busy};
  endfunction
  task automatic rd(input int n);
    logic [15:0] s;
    s = stat_m();
    host.sel();
    host.xb(8'h05, 8, rx);
    for (int i = 0; i < n; i++) begin
      host.xb(8'($urandom), 8, rx);
      `CHK("status", s[15 - 8 * (i % 2) -: 8], rx)
    end
    host.desel();
  endtask
  task automatic ws(input logic [7:0] op, input logic [7:0] d);
    host.sel();
    host.xb(op, 8, rx);
    host.xb(d, 8, rx);
    host.desel();
    if (core_in.write_enable_latch && op == 8'h01 && (wp_n || d[7])) lock_m = d[7];
    if (core_in.write_enable_latch && op == 8'h31) reset_command_enable_m = d[4];
  endtask
  initial begin
    reset = 1'b1;
    wp_n = 1'b1;
    core_in = '0;
    otp_wr = '0;
    tbl = '{{8'h01, 8'hFF, 2'h3}, {8'h01, 8'h00, 2'h1}, {8'h01, 8'h7F, 2'h2},
      {8'h01, 8'h7F, 2'h3}, {8'h31, 8'hFF, 2'h3}, {8'h01, 8'h80, 2'h1}};
    foreach (otp_m[i]) otp_m[i] = 8'hFF;
    void'($urandom(15302));
    repeat (5) tick();
    reset = 1'b0;
    repeat (4) tick();
    for (int k = 0; k < 8; k++) begin
      core_in = 7'(($urandom & 32'h74) | k[1:0]);
      wp_n = k[2];
      repeat (6) tick();
      rd(4);
    end
    $display("status test done");
    for (int k = 0; k < 3; k++) begin
      tick();
      core_in = 7'({k != 1, k == 0, 2'h0});
      tick();
      core_in.op_done = 1'b0;
      if (k != 1) err_m = k == 0;
      tick();
      `CHK("error", err_m[0], eflag)
      rd(2);
    end
    $display("error test done");
    foreach (tbl[k]) begin
      tick();
      {wp_n, core_in.write_enable_latch} = tbl[k][1:0];
      repeat (6) tick();
      ws(tbl[k][17:10], tbl[k][9:2]);
      `CHK("lock", lock_m[0], lock)
      `CHK("allow", !lock_m[0], allow)
      `CHK("reset_command_enable", reset_command_enable_m[0], reset_command_enable)
      rd(2);
    end
    tick();
    reset = 1'b1;
    tick();
    reset = 1'b0;
    lock_m = 0;
    reset_command_enable_m = 0;
    err_m = 0;
    repeat (4) tick();
    `CHK("lock", 1'b0, lock)
    rd(2);
    // Idle-low clock, mode 0
    host.sck = 1'b0;
    repeat (6) tick();
    rd(2);
    host.sck = 1'b1;
    repeat (6) tick();
    $display("write test done");
    for (int k = 0; k < 3; k++) begin
      tick();
      otp_wr = {1'b1, 7'(k + 126), 8'($urandom)};
      otp_m[otp_wr.addr] = otp_wr.data;
    end
    tick();
    otp_wr.we = 1'b0;
    host.gap = 300;
    host.sel();
    for (int i = 0; i < 10; i++) begin
      host.xb(i == 0 ? 8'h77 : i == 3 ? 8'h7E : 8'h00, 8, rx);
      if (i < 6) `CHK("quiet", 8'hzz, rx)
      else `CHK("otp", otp_m[7'(i + 120)], rx)
    end
    host.xb(8'h00, 3, rx);
    host.desel();
    `CHK("float", 2'b10, {so_oe_n, so})
    host.gap = 0;
    host.sel();
    host.xb(8'hA3, 8, rx);
    host.xb(8'h00, 8, rx);
    host.desel();
    `CHK("unknown", 8'hzz, rx)
    $display("read test done");
    final_report();
  end
endmodule

// File: spi_host_model.sv
// SPI host model in mode 3
`timescale 1ns/100ps
module spi_host_model (
  // Pins
  output logic      cs_n,
  output logic      sck,
  output logic      si,
  input  wire logic so,
  input  wire logic so_oe_n
);
  int gap = 0;
  initial begin
    cs_n = 1'b1;
    sck = 1'b1;
    si = 1'b0;
  end
  task automatic sel();
    cs_n = 1'b0;
    #200;
  endtask
  // Released data line flips so a stale level is never seen
  task automatic desel();
    #62.5 cs_n = 1'b1;
    si = ~si;
    #200;
  endtask
  task automatic xb(input logic [7:0] t, input int n, output logic [7:0] r);
    for (int i = 7; i > 7 - n; i--) begin
      sck = 1'b0;
      si = t[i];
      #62.5 sck = 1'b1;
      r[i] = so_oe_n ? 1'bz : so;
      #62.5;
    end
    #(gap);
  endtask
endmodule
